// file: shared/dpe_defines.svh
`ifndef DPE_DEFINES_SVH
`define DPE_DEFINES_SVH

// command codes and addresses
`define DPE_CMD_ENTER_PDCM 4'hb
`define DPE_CMD_REG_READ   4'h0
`define DPE_CMD_REG_WRITE  4'h8
`define DPE_GLOBAL_ADDR    4'h0

// response data field layout
`define DPE_CT_LSB         8
`define DPE_CT_MSB         11
`define DPE_RSV_DATA       16'h0000

// crc settings
`define DPE_CRC_POLY       8'h1d
`define DPE_CRC_SEED       8'hff

// reset values
`define DPE_INIT_RST       1'b0

`endif

// file: shared/dpe_pkg.sv
package dpe_pkg;

   // one dsi3 frame: address, command, data, crc
   typedef struct packed {
      logic [3:0]  addr;
      logic [3:0]  cmd;
      logic [15:0] data;
      logic [7:0]  crc;
   } dpe_frame_type;

   // communication mode enables
   typedef struct packed {
      logic cr;
      logic pdcm;
      logic bdm;
   } dpe_mode_type;

   typedef enum logic [1:0] {
      ST_CMDRSP   = 2'b01,
      ST_PERIODIC = 2'b10
   } dpe_state_type;

endpackage

// file: sim/dpe_master_model.sv
`timescale 1ns/10ps
`include "dpe_defines.svh"
module dpe_master_model
   import dpe_pkg::*;
(
   // bus clock
   input  wire logic clk_sys,
   // command frames toward the slave
   output logic          cmd_valid,
   output dpe_frame_type cmd_frame
);
   initial begin
      cmd_valid = 1'b0;
      cmd_frame = '0;
   end
   // header crc, msb first, no final xor
   function automatic logic [7:0] crc8(input logic [23:0] b);
      logic [7:0] c;
      c = `DPE_CRC_SEED;
      for (int i = 23; i >= 0; i--) begin
         c = (c[7] ^ b[i]) ? ({c[6:0], 1'b0} ^ `DPE_CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction
   // one frame for one cycle, crc spoilt on request
   task automatic send(input logic [3:0] a, c, input logic [15:0] d, input bit good);
      @(negedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_frame <= {a, c, d, crc8({a, c, d}) ^ {7'h00, !good}};
      @(negedge clk_sys);
      cmd_valid <= 1'b0;
      cmd_frame <= ~cmd_frame;
   endtask
endmodule // dpe_master_model

// file: sim/tb_top.sv
`timescale 1ns/10ps
`include "dpe_defines.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module tb_top
   import dpe_pkg::*;
;
   logic          clk_sys, sys_rst, cmd_valid, dme, init_done_flag;
   logic          config_lock, rw_verify_en, rsp_valid;
   logic [3:0]    node, ct;
   logic [31:0]   rs;
   dpe_frame_type cmd_frame, rsp_frame;
   dpe_mode_type  mode;
   int            bad_count, check_count;
   dpe_master_model u_dpe_master_model (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
      .cmd_frame(cmd_frame));
   dpe_decoder u_dpe_decoder (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd_frame(cmd_frame), .node_address_reg(node), .chip_time_value(ct),
      .diag_mode_enable(dme), .init_done_flag(init_done_flag), .mode(mode),
      .config_lock(config_lock), .rw_verify_en(rw_verify_en), .rsp_valid(rsp_valid),
      .rsp_frame(rsp_frame));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] rnd();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic reset_dut();
      @(negedge clk_sys);
      sys_rst = 1'b1;
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
   endtask
   task automatic check_status(input logic f);
      `CHK(init_done_flag, f)
      `CHK(config_lock, f)
      `CHK(rw_verify_en, f)
      `CHK(mode, f ? {2'b01, dme} : 3'b100)
   endtask
   // one command; answer stands for the one cycle after the edge following the taking edge
   task automatic run(input logic [3:0] a, c, input logic [15:0] d, input bit good, exp);
      logic [15:0]   ed;
      dpe_frame_type ef;
      ed = (c == `DPE_CMD_ENTER_PDCM) ? {4'h0, ct, 8'h00} : `DPE_RSV_DATA;
      ef = {a, c, ed, u_dpe_master_model.crc8({a, c, ed})};
      u_dpe_master_model.send(a, c, d, good);
      `CHK(rsp_valid, 1'b0)
      @(negedge clk_sys);
      `CHK(rsp_valid, exp)
      if (exp) `CHK(rsp_frame, ef)
      @(negedge clk_sys);
      `CHK(rsp_valid, 1'b0)
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(20000 * 5);
      bad_count++;
      finish_test();
   end
   initial begin
      rs = 32'd8812;
      sys_rst = 1'b1;
      dme = 1'b0;
      node = {3'(rnd()), 1'b1};
      ct = 4'(rnd());
      reset_dut();
      check_status(1'b0);
      for (int i = 1; i < 16; i++) begin
         if (i != 8 && i != 11) begin
            dme = 1'(rnd());
            run(node, i[3:0], 16'(rnd()), 1'b1, 1'b1);
            check_status(1'b0);
         end
      end
      run(node ^ 4'h1, 4'h5, 16'(rnd()), 1'b1, 1'b0);
      run(node, 4'h9, 16'(rnd()), 1'b0, 1'b0);
      run(node ^ 4'h2, 4'hb, 16'h0000, 1'b1, 1'b0);
      check_status(1'b0);
      run(node, 4'hb, 16'h0000, 1'b1, 1'b1);
      check_status(1'b1);
      dme = ~dme;
      repeat (2) @(negedge clk_sys);
      check_status(1'b1);
      run(node, 4'hc, 16'(rnd()), 1'b1, 1'b1);
      run(node, 4'hb, 16'h0000, 1'b1, 1'b1);
      check_status(1'b1);
      reset_dut();
      check_status(1'b0);
      run(`DPE_GLOBAL_ADDR, 4'hb, 16'h0000, 1'b1, 1'b0);
      check_status(1'b1);
      node = 4'h0;
      reset_dut();
      run(`DPE_GLOBAL_ADDR, 4'hb, 16'h0000, 1'b1, 1'b0);
      check_status(1'b1);
      finish_test();
   end
endmodule // tb_top

// file: src/dpe_crc8.sv
`timescale 1ns/10ps
`include "dpe_defines.svh"

module dpe_crc8 #(
   parameter logic [7:0] POLY = `DPE_CRC_POLY,
   parameter logic [7:0] SEED = `DPE_CRC_SEED
) (
   // header bits, msb first
   input  wire logic [23:0] bits_in,
   // computed crc
   output logic      [7:0]  crc_out
);

   always_comb begin
      logic [7:0] acc;
      logic       fb;
      acc = SEED;
      fb  = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         fb  = acc[7] ^ bits_in[i];
         acc = {acc[6:0], 1'b0};
         if (fb) begin
            acc = acc ^ POLY;
         end
      end
      crc_out = acc;
   end

endmodule // dpe_crc8

// file: src/dpe_decoder.sv
`timescale 1ns/10ps
`include "dpe_defines.svh"
// Overview of operation
// - addressed enter-periodic command sets init flag, enters periodic mode, responds.
// - global-address enter-periodic command sets init flag whatever the stored address.
// - no response frame for a global enter-periodic command.
// - enter-periodic command to any other address is silently dropped.
// - enter-periodic uses command code 1011, zero data, 8-bit crc.
// - before init, command-response mode only; periodic and diagnostic modes off.
// - after init, periodic on, command-response off, diagnostic follows its enable.
// - init flag locks configuration and turns on read/write array verification.
// - init flag is sticky; only device reset clears it.
// - enter response carries stored address, 1011, chip time in D11..D8.
// - reserved codes answered only on address match and valid crc.
// - reserved response echoes address and code with correct crc.
// - reserved code to a foreign address is ignored without response.

module dpe_decoder
   import dpe_pkg::*;
(
   // clock and reset
   input  wire logic          clk_sys,
   input  wire logic          sys_rst,
   // received command frame
   input  wire logic          cmd_valid,
   input  wire dpe_frame_type cmd_frame,
   // configuration inputs
   input  wire logic [3:0]    node_address_reg,
   input  wire logic [3:0]    chip_time_value,
   input  wire logic          diag_mode_enable,
   // status outputs
   output logic               init_done_flag,
   output dpe_mode_type       mode,
   output logic               config_lock,
   output logic               rw_verify_en,
   // response frame
   output logic               rsp_valid,
   output dpe_frame_type      rsp_frame
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic is_reserved(input logic [3:0] code);
      is_reserved = (code != `DPE_CMD_ENTER_PDCM) && (code != `DPE_CMD_REG_READ) &&
                    (code != `DPE_CMD_REG_WRITE);
   endfunction

   function automatic logic is_enter(input dpe_frame_type f);
      is_enter = (f.cmd == `DPE_CMD_ENTER_PDCM);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // crc check and generation

   logic [7:0]    rx_crc;
   logic [7:0]    tx_crc;
   logic          crc_ok;
   dpe_frame_type pend;
   logic          pend_valid;

   dpe_crc8 u_rx_crc (
      .bits_in (cmd_frame[31:8]),
      .crc_out (rx_crc)
   );

   dpe_crc8 u_tx_crc (
      .bits_in (pend[31:8]),
      .crc_out (tx_crc)
   );

   assign crc_ok = (rx_crc == cmd_frame.crc);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // command decode and mode control

   dpe_state_type state;
   dpe_state_type next_state;
   logic          next_init_done;
   logic          next_pend_valid;
   dpe_frame_type next_pend;
   dpe_mode_type  next_mode;
   logic          next_rsp_valid;
   dpe_frame_type next_rsp_frame;
   logic          glob_hit;
   logic          node_hit;

   assign glob_hit = (cmd_frame.addr == `DPE_GLOBAL_ADDR);
   assign node_hit = (cmd_frame.addr == node_address_reg);

   always_comb begin
      next_init_done  = init_done_flag;
      next_pend_valid = 1'b0;
      next_pend       = pend;
      if (cmd_valid && crc_ok) begin
         if (is_enter(cmd_frame)) begin
            if (glob_hit) begin
               next_init_done = 1'b1;
            end else if (node_hit) begin
               next_init_done  = 1'b1;
               next_pend_valid = 1'b1;
               next_pend       = '0;
               next_pend.addr  = node_address_reg;
               next_pend.cmd   = `DPE_CMD_ENTER_PDCM;
               next_pend.data[`DPE_CT_MSB:`DPE_CT_LSB] = chip_time_value;
            end
            // any other address falls through untouched
         end else if (is_reserved(cmd_frame.cmd) && node_hit) begin
            next_pend_valid = 1'b1;
            next_pend.addr  = node_address_reg;
            next_pend.cmd   = cmd_frame.cmd;
            next_pend.data  = `DPE_RSV_DATA;
            next_pend.crc   = 8'h00;
         end
         // reserved code to a foreign node: nothing
      end
      case (state)
         ST_CMDRSP:   next_state = next_init_done ? ST_PERIODIC : ST_CMDRSP;
         ST_PERIODIC: next_state = ST_PERIODIC;
         default:     next_state = ST_CMDRSP;
      endcase
      next_mode.cr   = (next_state == ST_CMDRSP);
      next_mode.pdcm = (next_state == ST_PERIODIC);
      next_mode.bdm  = (next_state == ST_PERIODIC) && diag_mode_enable;
      next_rsp_valid = pend_valid;
      next_rsp_frame = rsp_frame;
      if (pend_valid) begin
         next_rsp_frame     = pend;
         next_rsp_frame.crc = tx_crc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state          <= ST_CMDRSP;
         init_done_flag <= `DPE_INIT_RST;
         mode           <= '{cr: 1'b1, pdcm: 1'b0, bdm: 1'b0};
         config_lock    <= 1'b0;
         rw_verify_en   <= 1'b0;
         pend_valid     <= 1'b0;
         pend           <= '0;
         rsp_valid      <= 1'b0;
         rsp_frame      <= '0;
      end else begin
         state          <= next_state;
         init_done_flag <= next_init_done;
         mode           <= next_mode;
         config_lock    <= next_init_done;
         rw_verify_en   <= next_init_done;
         pend_valid     <= next_pend_valid;
         pend           <= next_pend;
         rsp_valid      <= next_rsp_valid;
         rsp_frame      <= next_rsp_frame;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence s_enter_addr;
      cmd_valid && crc_ok && is_enter(cmd_frame) && !glob_hit && node_hit;
   endsequence

   sequence s_enter_glob;
      cmd_valid && crc_ok && is_enter(cmd_frame) && glob_hit;
   endsequence

   sequence s_rsv_hit;
      cmd_valid && crc_ok && is_reserved(cmd_frame.cmd) && node_hit;
   endsequence

   AST_ADDR_ENTER_SETS: assert property (s_enter_addr |=> init_done_flag && mode.pdcm)
      else $error("addressed enter did not start periodic mode");

   AST_ADDR_ENTER_RSP: assert property (s_enter_addr |-> ##2 rsp_valid &&
         rsp_frame.cmd == `DPE_CMD_ENTER_PDCM && rsp_frame.addr == $past(cmd_frame.addr, 2) &&
         rsp_frame.data == {4'h0, $past(chip_time_value, 2), 8'h00})
      else $error("addressed enter response wrong or missing");

   AST_GLOBAL_SETS: assert property (s_enter_glob |=> init_done_flag)
      else $error("global enter did not set init flag");

   AST_GLOBAL_NO_RSP: assert property (s_enter_glob |-> ##2 !rsp_valid)
      else $error("response sent to global enter");

   AST_FOREIGN_DROP: assert property (cmd_valid && is_enter(cmd_frame) && !glob_hit &&
         !node_hit && !init_done_flag |=> !init_done_flag ##1 !rsp_valid)
      else $error("foreign enter was not discarded");

   AST_MODE_BEFORE: assert property (!init_done_flag |-> mode.cr && !mode.pdcm &&
         !mode.bdm)
      else $error("wrong modes before init");

   AST_MODE_AFTER: assert property (init_done_flag && $past(init_done_flag) |->
         !mode.cr && mode.pdcm && mode.bdm == $past(diag_mode_enable))
      else $error("wrong modes after init");

   AST_LOCK: assert property ((init_done_flag == config_lock) &&
         (init_done_flag == rw_verify_en))
      else $error("lock or verify not tied to init flag");

   AST_STICKY: assert property (init_done_flag |=> init_done_flag)
      else $error("init flag cleared without reset");

   AST_RSV_RSP: assert property (s_rsv_hit |-> ##2 rsp_valid &&
         rsp_frame.cmd == $past(cmd_frame.cmd, 2) && rsp_frame.addr == $past(cmd_frame.addr, 2))
      else $error("reserved command not echoed");

   AST_RSV_IGNORE: assert property (cmd_valid && is_reserved(cmd_frame.cmd) &&
         (!node_hit || !crc_ok) |-> ##2 !rsp_valid)
      else $error("response to ignored reserved command");

   // a response only ever follows an addressed enter or a reserved hit
   AST_RSP_ONLY_ON_HIT: assert property (rsp_valid |-> $past(cmd_valid && crc_ok &&
         node_hit && (is_reserved(cmd_frame.cmd) || (!glob_hit && is_enter(cmd_frame))), 2))
      else $error("response without an addressed command");

endmodule // dpe_decoder
